// *** dfbac_ctrl.sv ***
// Data flash byte access controller with Wishbone register slave
//
// Function
// - One byte per operation; value register low byte, pointer selects location.
// - A write erases the location then programs it, timed internally.
// - Indirect read hits the array when pointer top nibble is 0111.
// - Indirect read of an unimplemented array address returns zero.
// - Indirect path is read-only; no store reaches the array.
// - Protect configuration zero blocks every erase and write.
// - Read start fetches the byte into the value register next cycle.
// - Value register keeps the fetched byte until reread or overwritten.
// - Read start bit clears itself when the read completes.
// - Program start accepted only after 55h then AAh unlock writes.
// - Unlock steps must be back to back; disturbance aborts the operation.
// - CPU stalled from program start until the operation finishes.
// - Erase is a write of FFh with the normal steps.
// - Start on a protected address clears the start bit, memory unchanged.
// - Completion clears start bit, sets done flag, interrupts if enabled.
// - Fault flag set on protected start, reset mid-write, broken unlock.
// - Software may set the fault flag; hardware never clears it.
// - Fifteen-bit pointer; its top bit reads undefined while busy.
// - Region bit 6 selects the byte array when one.
// - Latch-only without erase only updates the latch, no memory operation.
// - Program permit clear refuses any erase or programming cycle.
// - Writing zero to the start bit does not abort an operation.
`timescale 1ns/1ps
// ==========================================================
// Operating notes
//
// Bus slave
// Classic single-cycle slave, one wait state.
// Taken when cyc and stb high and ack low.
// Ack and read data from flops, one cycle each.
// Low ack stops a double take of one request.
// Master drops stb at the ack edge.
// Register writes land at the taken edge.
// Read data samples registers at the taken edge.
// Unmapped reads give zero, still acked.
// Unmapped writes dropped, still acked.
// Lane 0 carries every low byte.
// Lane 1 carries upper pointer and value bits.
// Lanes 2 and 3 ignored on writes; lane 2 returns indirect read data.
// Sel gates writes only.
// Stall is advisory; CPU holds off while high.
//
// Pointer and value
// Pointer holds a fifteen-bit location.
// Array is one 128-byte pointer window.
// Locations off the window read zero.
// Value holds fourteen bits; low byte is data.
// Upper value bits are storage only.
// Value changes by software write or read.
// A running write uses pointer as it stands.
//
// Control bits
// Region, latch-only, permit: plain storage.
// Erase select set by software, cleared at end.
// Fault read/write; hardware only sets it.
// Software may write fault as one for tests.
// Start-program set only by an accepted start.
// Start-read never reads back as one.
// Zero to start-program while busy ignored.
//
// Read path
// Start-read, region one: fetch pointed byte.
// Byte sits in value register at ack edge.
// No stall; fetch takes one cycle.
// Start-read and region may share one write.
// Start-read ignored while a write runs.
// Region zero or off-array pointer reads zero.
//
// Unlock sequencer
// First key moves idle to first-key state.
// Second key moves on to second-key state.
// Next request must be the start write.
// Any other request between steps aborts.
// Wrong second key aborts the same way.
// Abort sets the fault flag.
// Idle cycles between steps tolerated.
// Keys checked on lane 0 only.
// Start write outside the sequence dropped.
// Software keeps interrupts off meanwhile.
//
// Start checks, highest first
// Permit clear: dropped, no fault.
// Protected, region one: dropped, fault.
// Latch-only, no erase: dropped, no fault.
// Latch-only ignored with erase selected.
// Otherwise the self-timed write begins.
//
// Self-timed write
// Counter loads programming time in cycles.
// Stall rises at the accepting edge.
// Counter steps down once per cycle.
// Byte stored at the last count.
// Erase and program collapse to one store.
// Region zero runs timer, stores nothing.
// End clears start-program and erase.
// End sets done flag; set beats clear.
// Stall falls with the store.
// Pointer writes while busy move the store.
//
// Interrupt
// Output is done flag and enable, registered.
// Enable alone does not raise it.
// Software clears done flag via status.
//
// Indirect window
// Top nibble 0111 steers into the array.
// Lower pointer bits select the byte.
// Read byte lags pointer by one cycle.
// Misses read zero.
// Pointer reads back in bits 15:0.
// No write path at all.
//
// Protection input
// Level passes two flops before use.
// Low blocks every array write.
// Change only with no start pending.
//
// Reset
// Synchronous; clears all but the array.
// Array contents survive reset.
// Flops read zero from first reset edge.
// In-flight flag seen one cycle after release.
// Set in-flight flag marks the fault.
//
// Limits
// No row latches; latch-only starts idle.
// No program flash behind region zero.
// Pointer top bit not masked while busy.

module dfbac_ctrl (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic wb_ack_o,
    output logic [31:0] wb_dat_o,
    input wire logic byte_array_protect_cfg,
    input wire logic write_in_flight_at_reset,
    output logic cpu_stall,
    output logic completion_irq
);
    // ==========================================================
    // Storage and state
    logic [7:0] byte_nv_array [dfbac_pkg::ARRAY_DEPTH];
    dfbac_pkg::dfbac_regs_t r_q;
    dfbac_pkg::dfbac_regs_t r_d;
    logic [7:0] arr_rd;
    logic [7:0] ind_rd;
    logic arr_we;
    logic boot_q;

    // Array address decode, used by the register and indirect paths
    localparam int ARRAY_AW = dfbac_pkg::ARRAY_AW;
    function automatic logic in_array(input logic [14:0] a);
        in_array = (a[14:ARRAY_AW] ==
            dfbac_pkg::ARRAY_BASE[14:dfbac_pkg::ARRAY_AW]);
    endfunction

    wire logic req = wb_cyc_i & wb_stb_i & ~r_q.ack;
    wire logic wr = req & wb_we_i;
    wire logic lane0 = wb_sel_i[0];
    wire logic [7:0] b0 = wb_dat_i[7:0];
    wire logic hit_ctl = (wb_adr_i == dfbac_pkg::ADDR_CTL);
    wire logic hit_key = (wb_adr_i == dfbac_pkg::ADDR_UNLOCK);
    wire logic [6:0] aidx = r_q.ptr[6:0];
    wire logic [6:0] iidx = r_q.iptr[6:0];

    // Array read ports
    assign arr_rd = byte_nv_array[aidx];
    assign ind_rd = byte_nv_array[iidx];

    // ==========================================================
    // Next-state logic
    always_comb begin
        r_d = r_q;
        r_d.ack = req;
        r_d.done = 1'b0;
        r_d.wp_s1 = byte_array_protect_cfg;
        r_d.wp_s2 = r_q.wp_s1;
        arr_we = 1'b0;
        // Register writes
        if (wr) begin
            case (wb_adr_i)
                dfbac_pkg::ADDR_PTR: begin
                    if (lane0) begin
                        r_d.ptr[7:0] = b0;
                    end
                    if (wb_sel_i[1]) begin
                        r_d.ptr[14:8] = wb_dat_i[14:8];
                    end
                end
                dfbac_pkg::ADDR_VAL: begin
                    if (lane0) begin
                        r_d.val[7:0] = b0;
                    end
                    if (wb_sel_i[1]) begin
                        r_d.val[13:8] = wb_dat_i[13:8];
                    end
                end
                dfbac_pkg::ADDR_CTL: begin
                    if (lane0) begin
                        r_d.ctl[dfbac_pkg::CTL_REGION] =
                            b0[dfbac_pkg::CTL_REGION];
                        r_d.ctl[dfbac_pkg::CTL_LATCH] =
                            b0[dfbac_pkg::CTL_LATCH];
                        r_d.ctl[dfbac_pkg::CTL_PERMIT] =
                            b0[dfbac_pkg::CTL_PERMIT];
                        r_d.ctl[dfbac_pkg::CTL_ERASE] =
                            r_q.ctl[dfbac_pkg::CTL_ERASE] |
                            b0[dfbac_pkg::CTL_ERASE];
                        r_d.ctl[dfbac_pkg::CTL_FAULT] =
                            b0[dfbac_pkg::CTL_FAULT];
                    end
                end
                dfbac_pkg::ADDR_STAT: begin
                    if (lane0) begin
                        r_d.irq_en = b0[dfbac_pkg::STAT_IRQE];
                        r_d.irq_flag = b0[dfbac_pkg::STAT_IRQF];
                    end
                end
                dfbac_pkg::ADDR_IPTR: begin
                    if (lane0) begin
                        r_d.iptr[7:0] = b0;
                    end
                    if (wb_sel_i[1]) begin
                        r_d.iptr[15:8] = wb_dat_i[15:8];
                    end
                end
                default: begin
                end
            endcase
        end
        // Indirect read, read-only path
        if (r_q.iptr[15:12] == dfbac_pkg::IND_NIBBLE &&
            in_array({1'b1, r_q.iptr[13:0]})) begin
            r_d.idata = ind_rd;
        end else begin
            r_d.idata = 8'h00;
        end
        // Read start: byte lands in value register next cycle
        if (wr && hit_ctl && lane0 && b0[dfbac_pkg::CTL_RD] &&
            r_q.st != dfbac_pkg::DFBAC_BUSY) begin
            if (b0[dfbac_pkg::CTL_REGION] && in_array(r_q.ptr)) begin
                r_d.val = {6'h00, arr_rd};
            end else begin
                r_d.val = 14'h0000;
            end
            r_d.ctl[dfbac_pkg::CTL_RD] = 1'b0;
        end
        // Unlock sequencer and self-timed write
        case (r_q.st)
            dfbac_pkg::DFBAC_IDLE: begin
                if (wr && hit_key && lane0 && b0 == dfbac_pkg::KEY_FIRST) begin
                    r_d.st = dfbac_pkg::DFBAC_KEY1;
                end else if (wr && hit_ctl && lane0 &&
                             b0[dfbac_pkg::CTL_WR]) begin
                    r_d.ctl[dfbac_pkg::CTL_WR] = 1'b0;
                end
            end
            dfbac_pkg::DFBAC_KEY1: begin
                if (req) begin
                    if (wr && hit_key && lane0 &&
                        b0 == dfbac_pkg::KEY_SECOND) begin
                        r_d.st = dfbac_pkg::DFBAC_KEY2;
                    end else begin
                        r_d.st = dfbac_pkg::DFBAC_IDLE;
                        r_d.ctl[dfbac_pkg::CTL_FAULT] = 1'b1;
                    end
                end
            end
            dfbac_pkg::DFBAC_KEY2: begin
                if (req) begin
                    r_d.st = dfbac_pkg::DFBAC_IDLE;
                    if (wr && hit_ctl && lane0 && b0[dfbac_pkg::CTL_WR]) begin
                        if (!b0[dfbac_pkg::CTL_PERMIT]) begin
                            r_d.ctl[dfbac_pkg::CTL_WR] = 1'b0;
                        end else if (!r_q.wp_s2 &&
                                     b0[dfbac_pkg::CTL_REGION]) begin
                            r_d.ctl[dfbac_pkg::CTL_WR] = 1'b0;
                            r_d.ctl[dfbac_pkg::CTL_FAULT] = 1'b1;
                        end else if (b0[dfbac_pkg::CTL_LATCH] &&
                                     !r_d.ctl[dfbac_pkg::CTL_ERASE]) begin
                            r_d.ctl[dfbac_pkg::CTL_WR] = 1'b0;
                        end else begin
                            r_d.ctl[dfbac_pkg::CTL_WR] = 1'b1;
                            r_d.cnt = 10'(dfbac_pkg::PROG_CYCLES);
                            r_d.stall = 1'b1;
                            r_d.st = dfbac_pkg::DFBAC_BUSY;
                        end
                    end else begin
                        r_d.ctl[dfbac_pkg::CTL_FAULT] = 1'b1;
                    end
                end
            end
            dfbac_pkg::DFBAC_BUSY: begin
                r_d.ctl[dfbac_pkg::CTL_WR] = 1'b1;
                if (r_q.cnt == 10'h001) begin
                    r_d.cnt = 10'h000;
                    r_d.stall = 1'b0;
                    r_d.done = 1'b1;
                    r_d.ctl[dfbac_pkg::CTL_WR] = 1'b0;
                    r_d.ctl[dfbac_pkg::CTL_ERASE] = 1'b0;
                    r_d.irq_flag = 1'b1;
                    r_d.st = dfbac_pkg::DFBAC_IDLE;
                    if (r_q.ctl[dfbac_pkg::CTL_REGION] &&
                        in_array(r_q.ptr)) begin
                        arr_we = 1'b1;
                    end
                end else begin
                    r_d.cnt = r_q.cnt - 10'h001;
                end
            end
            default: begin
                r_d.st = dfbac_pkg::DFBAC_IDLE;
            end
        endcase
        r_d.irq = r_d.irq_flag & r_d.irq_en;
        // Register readback
        r_d.rdat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                dfbac_pkg::ADDR_PTR: begin
                    r_d.rdat = {17'h00000, r_q.ptr};
                end
                dfbac_pkg::ADDR_VAL: r_d.rdat = {18'h00000, r_q.val};
                dfbac_pkg::ADDR_CTL: r_d.rdat = {24'h000000, r_q.ctl};
                dfbac_pkg::ADDR_STAT: begin
                    r_d.rdat = {30'h00000000, r_q.irq_en, r_q.irq_flag};
                end
                dfbac_pkg::ADDR_IPTR: begin
                    r_d.rdat = {8'h00, r_q.idata, r_q.iptr};
                end
                default: r_d.rdat = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // State register with synchronous reset
    always_ff @(posedge sys_clk) begin
        boot_q <= reset;
        if (reset) begin
            r_q <= '0;
            r_q.st <= dfbac_pkg::DFBAC_IDLE;
            r_q.ctl <= dfbac_pkg::RESET_CTL;
        end else begin
            r_q <= r_d;
            if (boot_q && write_in_flight_at_reset) begin
                r_q.ctl[dfbac_pkg::CTL_FAULT] <= 1'b1;
            end
        end
    end

    // Array write, erase-before-write collapses to a byte store
    always_ff @(posedge sys_clk) begin
        if (arr_we) begin
            byte_nv_array[aidx] <= r_q.val[7:0];
        end
    end

    // Outputs straight from flops
    assign wb_ack_o = r_q.ack;
    assign wb_dat_o = r_q.rdat;
    assign cpu_stall = r_q.stall;
    assign completion_irq = r_q.irq;
endmodule // dfbac_ctrl

// *** dfbac_pkg.sv ***
// Package for the data flash byte access controller
package dfbac_pkg;
    // ==========================================================
    // Register map (byte addresses on the Wishbone bus)
    localparam logic [15:0] ADDR_PTR = 16'h1C8C;
    localparam logic [15:0] ADDR_VAL = 16'h1C8E;
    localparam logic [15:0] ADDR_CTL = 16'h1C90;
    localparam logic [15:0] ADDR_UNLOCK = 16'h1C94;
    localparam logic [15:0] ADDR_STAT = 16'h1C98;
    localparam logic [15:0] ADDR_IPTR = 16'h1C9C;
    // ==========================================================
    // Control and status register bit positions
    localparam int CTL_RD = 0;
    localparam int CTL_WR = 1;
    localparam int CTL_PERMIT = 2;
    localparam int CTL_FAULT = 3;
    localparam int CTL_ERASE = 4;
    localparam int CTL_LATCH = 5;
    localparam int CTL_REGION = 6;
    localparam int STAT_IRQF = 0;
    localparam int STAT_IRQE = 1;
    // ==========================================================
    // Unlock keys, array geometry, indirect window
    localparam logic [7:0] KEY_FIRST = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'hAA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [3:0] IND_NIBBLE = 4'h7;
    localparam logic [14:0] ARRAY_BASE = 15'h7000;
    localparam int ARRAY_DEPTH = 128;
    localparam int ARRAY_AW = 7;
    localparam logic [7:0] RESET_CTL = 8'h00;
    // ==========================================================
    // Self-timed programming time
    localparam int PROG_TIME_NS = 4000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    // ==========================================================
    // Controller states
    typedef enum logic [3:0] {
        DFBAC_IDLE = 4'h1,
        DFBAC_KEY1 = 4'h2,
        DFBAC_KEY2 = 4'h4,
        DFBAC_BUSY = 4'h8
    } dfbac_state_t;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [15:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } dfbac_wb_req_t;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } dfbac_wb_rsp_t;
    typedef struct packed {
        dfbac_state_t st;
        logic [14:0] ptr;
        logic [13:0] val;
        logic [7:0] ctl;
        logic irq_flag;
        logic irq_en;
        logic [15:0] iptr;
        logic [7:0] idata;
        logic [9:0] cnt;
        logic stall;
        logic done;
        logic irq;
        logic ack;
        logic [31:0] rdat;
        logic wp_s1;
        logic wp_s2;
    } dfbac_regs_t;
endpackage

// *** dfbac_ctrl_monitor.sv ***
// Assertion checker for the data flash byte access controller
`timescale 1ns/1ps
module dfbac_ctrl_monitor (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic byte_array_protect_cfg,
    input wire logic write_in_flight_at_reset,
    input wire logic cpu_stall,
    input wire logic completion_irq
);
    // ==========================================================
    // Helper state
    localparam int HI = dfbac_pkg::PROG_CYCLES + 1;
    localparam int LO = dfbac_pkg::PROG_CYCLES - 1;
    logic taken;
    logic key1_q;
    logic armed_q;
    logic [10:0] cnt_q;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // New request on the bus
    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Unlock key tracking and stall length count
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            key1_q <= 1'h0;
            armed_q <= 1'h0;
            cnt_q <= 11'h000;
        end else begin
            if (taken) begin
                key1_q <= wb_we_i && wb_adr_i == dfbac_pkg::ADDR_UNLOCK
                    && wb_dat_i[7:0] == dfbac_pkg::KEY_FIRST;
                armed_q <= wb_we_i && wb_adr_i == dfbac_pkg::ADDR_UNLOCK
                    && wb_dat_i[7:0] == dfbac_pkg::KEY_SECOND && key1_q;
            end
            cnt_q <= cpu_stall ? cnt_q + 11'h001 : 11'h000;
        end
    end
    // ==========================================================
    // Properties
    property p_ack_resp;
        taken |=> wb_ack_o;
    endproperty
    a_ack_resp: assert property (p_ack_resp)
        else $error("ack missing after request");
    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_stall_cause;
        $rose(cpu_stall) |-> $past(wb_we_i && wb_adr_i ==
            dfbac_pkg::ADDR_CTL && wb_dat_i[dfbac_pkg::CTL_WR]);
    endproperty
    a_stall_cause: assert property (p_stall_cause)
        else $error("stall without start write");
    property p_unlock;
        $rose(cpu_stall) |-> $past(armed_q, 2);
    endproperty
    a_unlock: assert property (p_unlock)
        else $error("operation without unlock keys");
    property p_permit;
        $rose(cpu_stall) |-> $past(wb_dat_i[dfbac_pkg::CTL_PERMIT]);
    endproperty
    a_permit: assert property (p_permit)
        else $error("operation without permit");
    property p_protect;
        $rose(cpu_stall) |-> $past(byte_array_protect_cfg);
    endproperty
    a_protect: assert property (p_protect)
        else $error("operation on protected array");
    property p_latch;
        $rose(cpu_stall) |-> !$past(wb_dat_i[dfbac_pkg::CTL_LATCH])
            || $past(wb_dat_i[dfbac_pkg::CTL_ERASE]);
    endproperty
    a_latch: assert property (p_latch)
        else $error("memory operation in latch only mode");
    property p_stall_max;
        cpu_stall |-> cnt_q <= HI;
    endproperty
    a_stall_max: assert property (p_stall_max)
        else $error("stall too long");
    property p_stall_min;
        $fell(cpu_stall) |-> cnt_q >= LO;
    endproperty
    a_stall_min: assert property (p_stall_min)
        else $error("stall too short");
endmodule // dfbac_ctrl_monitor

// *** dfbac_cpu_model.sv ***
// CPU core model issuing classic Wishbone register accesses
`timescale 1ns/1ps
module dfbac_cpu_model (
    input wire logic sys_clk,
    output logic wb_cyc_o,
    output logic wb_stb_o,
    output logic wb_we_o,
    output logic [15:0] wb_adr_o,
    output logic [3:0] wb_sel_o,
    output logic [31:0] wb_dat_o,
    input wire logic wb_ack_i,
    input wire logic [31:0] wb_dat_i
);
    // Idle bus at time zero
    initial begin
        wb_cyc_o = 1'h0;
        wb_stb_o = 1'h0;
        wb_we_o = 1'h0;
        wb_adr_o = 16'h0000;
        wb_sel_o = 4'h0;
        wb_dat_o = 32'h0;
    end
    // One access; software runs with interrupts off, so unlock
    // steps follow each other undisturbed
    task automatic xfer(input logic we, input logic [15:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        wb_cyc_o <= 1'h1;
        wb_stb_o <= 1'h1;
        wb_we_o <= we;
        wb_adr_o <= a;
        wb_sel_o <= 4'hF;
        wb_dat_o <= d;
        do @(posedge sys_clk); while (wb_ack_i !== 1'h1);
        q = wb_dat_i;
        wb_cyc_o <= 1'h0;
        wb_stb_o <= 1'h0;
        wb_dat_o <= ~d;
    endtask
endmodule // dfbac_cpu_model

// *** data_flash_byte_access_ctrl_tb_top.sv ***
// Self-checking testbench for the data flash byte access controller
`timescale 1ns/1ps
module data_flash_byte_access_ctrl_tb_top;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic cfg = 1'h1;
    logic inflt = 1'h0;
    logic cyc, stb, we, ack, stall, irq;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, rdat, q;
    int bad_count = 0;
    int checks_done = 0;
    int cyc_n = 0;
    // ==========================================================
    // Design, CPU model, clock
    dfbac_ctrl i_dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
        .byte_array_protect_cfg(cfg), .write_in_flight_at_reset(inflt),
        .cpu_stall(stall), .completion_irq(irq));
    dfbac_cpu_model i_cpu (.sys_clk(sys_clk), .wb_cyc_o(cyc),
        .wb_stb_o(stb), .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel),
        .wb_dat_o(dat), .wb_ack_i(ack), .wb_dat_i(rdat));
    initial begin
        forever #2 sys_clk = ~sys_clk;
    end
    // ==========================================================
    // Helpers
    task automatic end_sim;
        if (bad_count == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        i_cpu.xfer(1'h1, a, d, q);
    endtask
    task automatic rd(input logic [15:0] a);
        i_cpu.xfer(1'h0, a, 32'h0, q);
    endtask
    // Register read of one array byte
    task automatic rdb(input logic [7:0] p, input logic [7:0] e);
        wr(dfbac_pkg::ADDR_PTR, {16'h0, 8'h70, p});
        wr(dfbac_pkg::ADDR_CTL, 32'h41);
        rd(dfbac_pkg::ADDR_VAL);
        chk("read byte", {24'h0, e}, {24'h0, q[7:0]});
        rd(dfbac_pkg::ADDR_VAL);
        chk("held byte", {24'h0, e}, {24'h0, q[7:0]});
        rd(dfbac_pkg::ADDR_CTL);
        chk("read start clear", 32'h0, {31'h0, q[0]});
    endtask
    // Unlocked start; brk puts a foreign access between the keys
    task automatic run(input logic [7:0] v, input logic [7:0] c,
        input logic brk, input logic busy);
        logic seen;
        logic [7:0] keep;
        seen = 1'h0;
        keep = 8'h00;
        wr(dfbac_pkg::ADDR_PTR, 32'h7003);
        wr(dfbac_pkg::ADDR_VAL, {24'h0, v});
        wr(dfbac_pkg::ADDR_CTL, {24'h0, c & 8'hFD});
        wr(dfbac_pkg::ADDR_UNLOCK, 32'h55);
        if (brk) rd(dfbac_pkg::ADDR_STAT);
        wr(dfbac_pkg::ADDR_UNLOCK, 32'hAA);
        // Keep the fault bit, as a bit-set store would
        if (brk) begin
            rd(dfbac_pkg::ADDR_CTL);
            keep = q[7:0] & 8'h08;
        end
        wr(dfbac_pkg::ADDR_CTL, {24'h0, c | keep});
        repeat (3) begin
            @(negedge sys_clk);
            seen = seen | (stall === 1'h1);
        end
        chk("stall", {31'h0, busy}, {31'h0, seen});
        while (stall !== 1'h0) @(negedge sys_clk);
        rd(dfbac_pkg::ADDR_CTL);
        chk("start clear", 32'h0, {31'h0, q[1]});
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(dfbac_pkg::ADDR_CTL);
        chk("ctl reset", {24'h0, dfbac_pkg::RESET_CTL}, q);
        rd(16'h1CA0);
        chk("unmapped", 32'h0, q);
    endtask
    task automatic t_write;
        wr(dfbac_pkg::ADDR_STAT, 32'h2);
        run(8'h5A, 8'h46, 1'h0, 1'h1);
        chk("irq", 32'h1, {31'h0, irq});
        rd(dfbac_pkg::ADDR_STAT);
        chk("done flag", 32'h1, {31'h0, q[0]});
        rdb(8'h03, 8'h5A);
        wr(dfbac_pkg::ADDR_IPTR, 32'h7003);
        rd(dfbac_pkg::ADDR_IPTR);
        chk("indirect", 32'h5A, {24'h0, q[23:16]});
        wr(dfbac_pkg::ADDR_IPTR, 32'h7F00);
        rd(dfbac_pkg::ADDR_IPTR);
        chk("indirect void", 32'h0, {24'h0, q[23:16]});
        run(8'hFF, 8'h46, 1'h0, 1'h1);
        rdb(8'h03, 8'hFF);
        wr(dfbac_pkg::ADDR_STAT, 32'h0);
        @(negedge sys_clk);
        chk("irq off", 32'h0, {31'h0, irq});
    endtask
    // No permit, broken unlock, protected array, latch only
    task automatic t_block;
        logic [7:0] ct [4] = '{8'h42, 8'h46, 8'h46, 8'h66};
        logic [3:0] bk = 4'h2;
        logic [3:0] pc = 4'hB;
        logic [3:0] ft = 4'h6;
        for (int i = 0; i < 4; i++) begin
            cfg <= pc[i];
            repeat (4) @(posedge sys_clk);
            run(8'h11, ct[i], bk[i], 1'h0);
            if (ft[i]) chk("fault", 32'h1, {31'h0, q[3]});
            wr(dfbac_pkg::ADDR_CTL, 32'h0);
            rdb(8'h03, 8'hFF);
        end
        cfg <= 1'h1;
        run(8'h22, 8'h06, 1'h0, 1'h1);
        rdb(8'h03, 8'hFF);
        wr(dfbac_pkg::ADDR_CTL, 32'h8);
        repeat (2) rd(dfbac_pkg::ADDR_CTL);
        chk("fault kept", 32'h1, {31'h0, q[3]});
    endtask
    task automatic t_inflight;
        @(posedge sys_clk);
        reset <= 1'h1;
        inflt <= 1'h1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'h0;
        @(posedge sys_clk);
        inflt <= 1'h0;
        rd(dfbac_pkg::ADDR_CTL);
        chk("reset fault", 32'h1, {31'h0, q[3]});
    endtask
    // ==========================================================
    // Main sequence and timeout
    initial begin
        repeat (5) @(posedge sys_clk);
        reset <= 1'h0;
        t_reset();
        t_write();
        t_block();
        t_inflight();
        end_sim();
    end
    always @(posedge sys_clk) begin
        cyc_n++;
        if (cyc_n == 40000) begin
            bad_count++;
            end_sim();
        end
    end
endmodule // data_flash_byte_access_ctrl_tb_top
bind dfbac_ctrl dfbac_ctrl_monitor i_mon (.sys_clk(sys_clk),
    .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .byte_array_protect_cfg(byte_array_protect_cfg),
    .write_in_flight_at_reset(write_in_flight_at_reset),
    .cpu_stall(cpu_stall), .completion_irq(completion_irq));
